// ===== core/aftr_pkg.sv
// Constants and register map of the alarm flag and timing trim bank.
package aftr_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int TRIM_W = 8;
  localparam int NUM_TRIM = 6;
  localparam int DIV_W = 4;
  localparam int FRAME_BITS = 24;
  localparam int HDR_BITS = 16;
  localparam logic [4:0] CNT_ADDR_DONE = 5'h0f;
  localparam logic [4:0] CNT_LAST_BIT = 5'h17;
  localparam logic [4:0] CNT_DATA_START = 5'h10;

  localparam logic [ADDR_W-1:0] OFS_SUMMARY = 15'h02c0;
  localparam logic [ADDR_W-1:0] OFS_ALARM_FLAGS = 15'h02c1;
  localparam logic [ADDR_W-1:0] OFS_ALARM_SUPPRESS = 15'h02c2;
  localparam logic [ADDR_W-1:0] OFS_TRIM_A_DUAL = 15'h0310;
  localparam logic [ADDR_W-1:0] OFS_TRIM_B_DUAL = 15'h0313;
  localparam logic [ADDR_W-1:0] OFS_TRIM_A_IL_IN_A = 15'h0314;
  localparam logic [ADDR_W-1:0] OFS_TRIM_B_IL_IN_A = 15'h0315;
  localparam logic [ADDR_W-1:0] OFS_TRIM_A_IL_IN_B = 15'h031a;
  localparam logic [ADDR_W-1:0] OFS_TRIM_B_IL_IN_B = 15'h031b;

  localparam int BIT_PHASE_REALIGN = 2;
  localparam int BIT_DIVIDER_MISMATCH = 0;
  localparam logic [DATA_W-1:0] ALARM_BITS = 8'h05;
  localparam logic [DATA_W-1:0] RST_ALARM_FLAGS = 8'h05;
  localparam logic [DATA_W-1:0] RST_ALARM_SUPPRESS = 8'h05;
  localparam logic [TRIM_W-1:0] RST_TRIM = 8'h00;
  localparam logic [2:0] TRIM_NONE = 3'h7;
endpackage

// ===== core/aftr_serial_port.sv
// Serial control port slave: framing, register strobes and read shifting.
module aftr_serial_port
  import aftr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic scs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic [DATA_W-1:0] rdata,
  output logic sdo,
  output logic sdo_oe,
  output logic wr,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] wdata
);
  typedef struct packed {
    logic scs_m;
    logic scs_s;
    logic sclk_m;
    logic sclk_s;
    logic sclk_d;
    logic sdi_m;
    logic sdi_s;
    logic [4:0] cnt;
    logic [FRAME_BITS-2:0] shift;
    logic [DATA_W-1:0] out;
    logic is_read;
    logic rd;
    logic wr;
    logic sdo;
    logic sdo_oe;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } aftr_spi_t;

  aftr_spi_t s;
  aftr_spi_t next_s;
  logic rise;
  logic fall;

  always_comb
  begin
    next_s = s;
    next_s.scs_m = scs_n;
    next_s.scs_s = s.scs_m;
    next_s.sclk_m = sclk;
    next_s.sclk_s = s.sclk_m;
    next_s.sclk_d = s.sclk_s;
    next_s.sdi_m = sdi;
    next_s.sdi_s = s.sdi_m;
    next_s.wr = 1'b0;
    next_s.rd = 1'b0;
    rise = s.sclk_s & ~s.sclk_d;
    fall = ~s.sclk_s & s.sclk_d;
    if (s.scs_s)
    begin
      next_s.cnt = 5'h00;
      next_s.sdo_oe = 1'b0;
      next_s.is_read = 1'b0;
    end
    else
    begin
      if (rise)
      begin
        next_s.shift = {s.shift[FRAME_BITS-3:0], s.sdi_s};
        next_s.cnt = s.cnt + 5'h01;
        if (s.cnt == CNT_ADDR_DONE)
        begin
          next_s.addr = {s.shift[ADDR_W-2:0], s.sdi_s};
          next_s.is_read = s.shift[ADDR_W-1];
          next_s.rd = s.shift[ADDR_W-1];
        end
        if (s.cnt == CNT_LAST_BIT && !s.is_read)
        begin
          next_s.wdata = {s.shift[DATA_W-2:0], s.sdi_s};
          next_s.wr = 1'b1;
        end
      end
      // The read word is captured one cycle after the address is known.
      if (s.rd)
        next_s.out = rdata;
      if (fall && s.is_read && s.cnt >= CNT_DATA_START)
      begin
        next_s.sdo = s.out[DATA_W-1];
        next_s.out = {s.out[DATA_W-2:0], 1'b0};
        next_s.sdo_oe = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.scs_m <= 1'b1;
      s.scs_s <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign sdo = s.sdo;
  assign sdo_oe = s.sdo_oe;
  assign wr = s.wr;
  assign addr = s.addr;
  assign wdata = s.wdata;
endmodule

// ===== core/aftr_bank.sv
// Alarm flags, alarm suppress mask, summary alarm and sampling trim bank.
// Summary of operation
// - A reference pulse that moves the internal clock phase sets the realign flag at bit 2, and writing one clears it.
// - Disagreeing A and B clock dividers set the divider mismatch flag at bit 0, and writing one clears it.
// - Power-on or soft reset sets every alarm flag so the flag register reads 0x05.
// - Suppress bit 2 keeps the realign flag out of the summary alarm while the flag still records.
// - Suppress bit 0 keeps the divider mismatch flag out of the summary alarm.
// - The suppress register resets to 0x05 so both alarms start suppressed.
// - Each trim register holds an eight-bit sampling instant shift in bits 7-0.
// - After reset release every trim register is loaded from its factory fuse value.
// - Software can read the trim values and overwrite them, and the new values drive the cores.
// - Each core and mode combination has its own trim register.
// - The read-only summary bit is high when any flag is set with its suppress bit clear.
// - A source select can route the summary alarm onto the calibration status pin.
module aftr_bank
  import aftr_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic SOFT_RST,
  input wire logic SCS_N,
  input wire logic SCLK,
  input wire logic SDI,
  input wire logic REALIGN_EVT,
  input wire logic [DIV_W-1:0] DIV_A,
  input wire logic [DIV_W-1:0] DIV_B,
  input wire logic [NUM_TRIM*TRIM_W-1:0] FUSE_TRIM,
  input wire logic CAL_STAT_SEL,
  input wire logic CAL_BUSY,
  output logic SDO,
  output logic SDO_OE,
  output logic ALARM,
  output logic CAL_STAT,
  output logic [TRIM_W-1:0] TRIM_A_DUAL,
  output logic [TRIM_W-1:0] TRIM_B_DUAL,
  output logic [TRIM_W-1:0] TRIM_A_IL_IN_A,
  output logic [TRIM_W-1:0] TRIM_B_IL_IN_A,
  output logic [TRIM_W-1:0] TRIM_A_IL_IN_B,
  output logic [TRIM_W-1:0] TRIM_B_IL_IN_B
);
  typedef struct packed {
    logic [DATA_W-1:0] flags;
    logic [DATA_W-1:0] suppress;
    logic [NUM_TRIM-1:0][TRIM_W-1:0] trim;
    logic loaded;
    logic alarm;
    logic cal_stat;
  } aftr_state_t;

  aftr_state_t s;
  aftr_state_t next_s;
  logic wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] events;

  function automatic logic [2:0] trim_index(input logic [ADDR_W-1:0] a);
    logic [2:0] idx;
    idx = TRIM_NONE;
    if (a == OFS_TRIM_A_DUAL)
      idx = 3'h0;
    else if (a == OFS_TRIM_B_DUAL)
      idx = 3'h1;
    else if (a == OFS_TRIM_A_IL_IN_A)
      idx = 3'h2;
    else if (a == OFS_TRIM_B_IL_IN_A)
      idx = 3'h3;
    else if (a == OFS_TRIM_A_IL_IN_B)
      idx = 3'h4;
    else if (a == OFS_TRIM_B_IL_IN_B)
      idx = 3'h5;
    return idx;
  endfunction

  aftr_serial_port u_port (
    .clk(CLK_SYS),
    .rst(RST),
    .scs_n(SCS_N),
    .sclk(SCLK),
    .sdi(SDI),
    .rdata(rdata),
    .sdo(SDO),
    .sdo_oe(SDO_OE),
    .wr(wr),
    .addr(addr),
    .wdata(wdata)
  );

  always_comb
  begin
    events = '0;
    events[BIT_PHASE_REALIGN] = REALIGN_EVT;
    events[BIT_DIVIDER_MISMATCH] = (DIV_A != DIV_B);
    rdata = '0;
    if (addr == OFS_SUMMARY)
      rdata = {7'h00, s.alarm};
    else if (addr == OFS_ALARM_FLAGS)
      rdata = s.flags;
    else if (addr == OFS_ALARM_SUPPRESS)
      rdata = s.suppress;
    else if (trim_index(addr) != TRIM_NONE)
      rdata = s.trim[trim_index(addr)];
  end

  always_comb
  begin
    next_s = s;
    if (wr && addr == OFS_ALARM_FLAGS)
      next_s.flags = s.flags & ~(wdata & ALARM_BITS);
    if (wr && addr == OFS_ALARM_SUPPRESS)
      next_s.suppress = wdata & ALARM_BITS;
    if (wr && trim_index(addr) != TRIM_NONE)
      next_s.trim[trim_index(addr)] = wdata;
    // Setting after clearing lets a coincident event win.
    next_s.flags = next_s.flags | events;
    // Fuse values are taken after RST release, and after the first SOFT_RST cycle even while it stays high.
    if (!s.loaded)
    begin
      next_s.trim = FUSE_TRIM;
      next_s.loaded = 1'b1;
    end
    if (SOFT_RST)
    begin
      next_s.flags = RST_ALARM_FLAGS;
      next_s.suppress = RST_ALARM_SUPPRESS;
      next_s.loaded = 1'b0;
    end
    next_s.alarm = |(next_s.flags & ~next_s.suppress & ALARM_BITS);
    next_s.cal_stat = CAL_STAT_SEL ? next_s.alarm : CAL_BUSY;
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      s <= '0;
      s.flags <= RST_ALARM_FLAGS;
      s.suppress <= RST_ALARM_SUPPRESS;
    end
    else
      s <= next_s;
  end

  assign ALARM = s.alarm;
  assign CAL_STAT = s.cal_stat;
  assign TRIM_A_DUAL = s.trim[0];
  assign TRIM_B_DUAL = s.trim[1];
  assign TRIM_A_IL_IN_A = s.trim[2];
  assign TRIM_B_IL_IN_A = s.trim[3];
  assign TRIM_A_IL_IN_B = s.trim[4];
  assign TRIM_B_IL_IN_B = s.trim[5];

  sequence s_clear_realign;
    wr && addr == OFS_ALARM_FLAGS && wdata[BIT_PHASE_REALIGN] && !SOFT_RST;
  endsequence

  property p_realign_sets;
    @(posedge CLK_SYS) disable iff (RST)
    REALIGN_EVT |=> s.flags[BIT_PHASE_REALIGN];
  endproperty
  a_realign_sets: assert property (p_realign_sets)
    else $error("realign event did not set its flag");

  property p_divider_sets;
    @(posedge CLK_SYS) disable iff (RST)
    DIV_A != DIV_B |=> s.flags[BIT_DIVIDER_MISMATCH];
  endproperty
  a_divider_sets: assert property (p_divider_sets)
    else $error("divider mismatch did not set its flag");

  property p_realign_clears;
    @(posedge CLK_SYS) disable iff (RST)
    s_clear_realign and !REALIGN_EVT |=> !s.flags[BIT_PHASE_REALIGN];
  endproperty
  a_realign_clears: assert property (p_realign_clears)
    else $error("write of one did not clear realign flag");

  property p_set_wins;
    @(posedge CLK_SYS) disable iff (RST)
    s_clear_realign and REALIGN_EVT |=> s.flags[BIT_PHASE_REALIGN];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("coincident event lost to clear");

  property p_zero_keeps;
    @(posedge CLK_SYS) disable iff (RST)
    wr && addr == OFS_ALARM_FLAGS && !wdata[BIT_PHASE_REALIGN]
      && s.flags[BIT_PHASE_REALIGN] |=> s.flags[BIT_PHASE_REALIGN];
  endproperty
  a_zero_keeps: assert property (p_zero_keeps)
    else $error("write of zero cleared a flag");

  property p_soft_reset;
    @(posedge CLK_SYS) disable iff (RST)
    SOFT_RST |=> s.flags == RST_ALARM_FLAGS
      && s.suppress == RST_ALARM_SUPPRESS ##1 s.loaded;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset values wrong");

  property p_summary;
    @(posedge CLK_SYS) disable iff (RST)
    ALARM == ((s.flags[BIT_PHASE_REALIGN] && !s.suppress[BIT_PHASE_REALIGN])
      || (s.flags[BIT_DIVIDER_MISMATCH]
      && !s.suppress[BIT_DIVIDER_MISMATCH]));
  endproperty
  a_summary: assert property (p_summary)
    else $error("summary alarm disagrees with flags and suppress");

  property p_realign_masked;
    @(posedge CLK_SYS) disable iff (RST)
    s.suppress[BIT_PHASE_REALIGN] && !s.flags[BIT_DIVIDER_MISMATCH]
      |-> !ALARM;
  endproperty
  a_realign_masked: assert property (p_realign_masked)
    else $error("suppressed realign flag raised the alarm");

  property p_pin_route;
    @(posedge CLK_SYS) disable iff (RST)
    CAL_STAT_SEL |=> CAL_STAT == ALARM;
  endproperty
  a_pin_route: assert property (p_pin_route)
    else $error("status pin does not follow summary alarm");

  property p_fuse_load;
    @(posedge CLK_SYS) disable iff (RST)
    !s.loaded && !SOFT_RST |=> s.loaded && s.trim == $past(FUSE_TRIM);
  endproperty
  a_fuse_load: assert property (p_fuse_load)
    else $error("trim not loaded from fuse value");

  property p_trim_write;
    @(posedge CLK_SYS) disable iff (RST)
    wr && addr == OFS_TRIM_B_IL_IN_B && s.loaded
      |=> TRIM_B_IL_IN_B == $past(wdata) && TRIM_A_DUAL == $past(TRIM_A_DUAL);
  endproperty
  a_trim_write: assert property (p_trim_write)
    else $error("trim write did not take effect alone");
endmodule

// ===== testbench/tb_alarm_flags_and_timing_trim_regs.sv
// Self-checking testbench of the alarm flag and timing trim bank.
module tb_alarm_flags_and_timing_trim_regs
  import aftr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [47:0] FUSE = 48'hc6b5a4938271;
  localparam logic [ADDR_W-1:0] TADR [6] = '{OFS_TRIM_A_DUAL,
    OFS_TRIM_B_DUAL, OFS_TRIM_A_IL_IN_A, OFS_TRIM_B_IL_IN_A,
    OFS_TRIM_A_IL_IN_B, OFS_TRIM_B_IL_IN_B};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic soft_rst = 1'b0;
  logic scs_n = 1'b1;
  logic sclk = 1'b0;
  logic sdi = 1'b0;
  logic realign = 1'b0;
  logic [DIV_W-1:0] div_a = '0;
  logic [DIV_W-1:0] div_b = '0;
  logic cal_sel = 1'b0;
  logic cal_busy = 1'b0;
  logic sdo;
  logic sdo_oe;
  logic alarm;
  logic cal_stat;
  logic [TRIM_W-1:0] trim [6];
  int mismatches = 0;
  int n_tests = 0;

  aftr_bank dut (.CLK_SYS(clk), .RST(rst), .SOFT_RST(soft_rst),
    .SCS_N(scs_n), .SCLK(sclk), .SDI(sdi), .REALIGN_EVT(realign),
    .DIV_A(div_a), .DIV_B(div_b), .FUSE_TRIM(FUSE),
    .CAL_STAT_SEL(cal_sel), .CAL_BUSY(cal_busy), .SDO(sdo), .SDO_OE(sdo_oe),
    .ALARM(alarm), .CAL_STAT(cal_stat), .TRIM_A_DUAL(trim[0]),
    .TRIM_B_DUAL(trim[1]), .TRIM_A_IL_IN_A(trim[2]),
    .TRIM_B_IL_IN_A(trim[3]), .TRIM_A_IL_IN_B(trim[4]),
    .TRIM_B_IL_IN_B(trim[5]));

  initial
  begin
    forever #5 clk = ~clk;
  end

  task automatic give_verdict();
    if (mismatches == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // SCLK phases of five cycles leave room for the three-cycle sync delay.
  task automatic xfer(input logic rd, input logic [ADDR_W-1:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    logic [23:0] f;
    f = {rd, a, d};
    q = '0;
    @(posedge clk);
    scs_n <= 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      sdi <= f[i];
      cyc(5);
      if (i < 8)
        q[i] = sdo;
      if (i == 0)
        chk("sdo oe", {7'h0, rd}, {7'h0, sdo_oe});
      sclk <= 1'b1;
      cyc(5);
      sclk <= 1'b0;
    end
    cyc(5);
    scs_n <= 1'b1;
    cyc(8);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b0, a, d, q);
  endtask

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [7:0] exp,
                      input string what);
    logic [7:0] q;
    xfer(1'b1, a, 8'h00, q);
    chk(what, exp, q);
    chk("sdo oe idle", 8'h00, {7'h0, sdo_oe});
  endtask

  task automatic pulse();
    @(posedge clk);
    realign <= 1'b1;
    @(posedge clk);
    realign <= 1'b0;
    cyc(3);
  endtask

  task automatic t_defaults();
    rchk(OFS_ALARM_FLAGS, 8'h05, "flags");
    rchk(OFS_ALARM_SUPPRESS, 8'h05, "suppress");
    chk("alarm", 8'h00, {7'h0, alarm});
    for (int i = 0; i < 6; i++)
    begin
      chk("trim out", FUSE[i*8+:8], trim[i]);
      rchk(TADR[i], FUSE[i*8+:8], "trim read");
    end
  endtask

  // Inverted fuse bytes flip every bit of every trim register.
  task automatic t_trims();
    for (int i = 0; i < 6; i++)
      wr(TADR[i], ~FUSE[i*8+:8]);
    for (int i = 0; i < 6; i++)
    begin
      chk("trim out", ~FUSE[i*8+:8], trim[i]);
      rchk(TADR[i], ~FUSE[i*8+:8], "trim read");
    end
  endtask

  task automatic t_alarms();
    wr(OFS_ALARM_FLAGS, 8'hff);
    rchk(OFS_ALARM_FLAGS, 8'h00, "flags");
    wr(OFS_ALARM_SUPPRESS, 8'h00);
    cal_sel <= 1'b1;
    pulse();
    chk("alarm", 8'h01, {7'h0, alarm});
    chk("cal stat", 8'h01, {7'h0, cal_stat});
    rchk(OFS_ALARM_FLAGS, 8'h04, "flags");
    rchk(OFS_SUMMARY, 8'h01, "summary");
    wr(OFS_ALARM_FLAGS, 8'h01);
    rchk(OFS_ALARM_FLAGS, 8'h04, "flags");
    wr(OFS_ALARM_FLAGS, 8'h04);
    rchk(OFS_ALARM_FLAGS, 8'h00, "flags");
    chk("alarm", 8'h00, {7'h0, alarm});
    wr(OFS_ALARM_SUPPRESS, 8'h04);
    pulse();
    chk("alarm", 8'h00, {7'h0, alarm});
    rchk(OFS_ALARM_FLAGS, 8'h04, "flags");
    // Events on every cycle of the frame also hit the clearing cycle.
    realign <= 1'b1;
    wr(OFS_ALARM_FLAGS, 8'h04);
    realign <= 1'b0;
    rchk(OFS_ALARM_FLAGS, 8'h04, "flags");
    cal_sel <= 1'b0;
    cal_busy <= 1'b1;
    cyc(3);
    chk("cal stat", 8'h01, {7'h0, cal_stat});
    div_b <= 4'h3;
    wr(OFS_ALARM_FLAGS, 8'h05);
    rchk(OFS_ALARM_FLAGS, 8'h01, "flags");
    chk("alarm", 8'h01, {7'h0, alarm});
    wr(OFS_ALARM_SUPPRESS, 8'h05);
    chk("alarm", 8'h00, {7'h0, alarm});
    div_b <= 4'h0;
    cal_busy <= 1'b0;
    wr(OFS_ALARM_FLAGS, 8'h01);
    rchk(OFS_ALARM_FLAGS, 8'h00, "flags");
    chk("cal stat", 8'h00, {7'h0, cal_stat});
    wr(15'h02c3, 8'hff);
    rchk(15'h02c3, 8'h00, "unmapped");
  endtask

  task automatic t_soft();
    @(posedge clk);
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
    cyc(3);
    for (int i = 0; i < 6; i++)
      chk("trim out", FUSE[i*8+:8], trim[i]);
    rchk(OFS_ALARM_FLAGS, 8'h05, "flags");
    rchk(OFS_ALARM_SUPPRESS, 8'h05, "suppress");
  endtask

  initial
  begin
    cyc(10);
    rst <= 1'b0;
    cyc(2);
    t_defaults();
    t_trims();
    t_alarms();
    t_soft();
    give_verdict();
  end

  // About 42 frames of some 254 cycles each fit well inside this span.
  initial
  begin
    cyc(60000);
    mismatches++;
    give_verdict();
  end
endmodule
